// File: cmf_consts.svh
// register offsets, field positions and reset values of the message object filter block
`ifndef CMF_CONSTS_SVH
`define CMF_CONSTS_SVH
`define CMF_NUM_OBJ        6
`define CMF_OBJ_BITS       3
`define CMF_IDX_BITS       3
`define CMF_MEM_DEPTH      48
`define CMF_MEM_ABITS      6
// register indices as printed (two are not word aligned, so byte address = 4 * index)
`define CMF_IDX_TAG        8'hF0
`define CMF_IDX_MASK       8'hF4
`define CMF_IDX_STAMP      8'hF8
`define CMF_IDX_DATA       8'hFA
`define CMF_IDX_PAGE       8'hFB
`define CMF_IDX_STATUS     8'hFC
// field positions
`define CMF_MSK_ID_LSB     3
`define CMF_MSK_RTR_BIT    2
`define CMF_MSK_IDE_BIT    0
`define CMF_TAG_RB1_BIT    1
`define CMF_TAG_RB0_BIT    0
`define CMF_PAGE_IDX_LSB   0
`define CMF_PAGE_AINC_BIT  3
`define CMF_PAGE_OBJ_LSB   4
`define CMF_MASK_RESET     32'h0000_0000
`define CMF_TAG_RESET      32'h0000_0000
`define CMF_PAGE_RESET     8'h00
`endif

// File: cmf_pkg.sv
// types shared by the message object filter block
package cmf_pkg;
    typedef struct packed {
        logic [28:0] ident;
        logic        rtr;
        logic        ide;
        logic        rb1;
        logic        rb0;
    } cmf_frame_t;

    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cmf_mem_req_t;

    typedef enum logic [1:0] {
        CMF_IDLE   = 2'b00,
        CMF_ACCESS = 2'b01,
        CMF_DONE   = 2'b10
    } cmf_bus_state_t;
endpackage

// File: cmf_byte_mem.sv
// message data byte store, eight bytes per message object, registered read
`timescale 1ns/1ns
`include "cmf_consts.svh"
module cmf_byte_mem (
    // clock
    input  wire logic                 clk,
    // software port
    input  wire cmf_pkg::cmf_mem_req_t sw_req,
    output logic [7:0]                sw_rdata,
    // protocol engine port, writes received bytes
    input  wire logic                 eng_we,
    input  wire logic [5:0]           eng_addr,
    input  wire logic [7:0]           eng_wdata
);
    logic [7:0] mem_reg [0:`CMF_MEM_DEPTH-1];
    logic [7:0] rdata_reg;

    // software write wins if both hit the same byte in one cycle
    always_ff @(posedge clk) begin
        if (eng_we)
            mem_reg[eng_addr] <= eng_wdata;
        if (sw_req.write)
            mem_reg[sw_req.addr] <= sw_req.wdata;
        rdata_reg <= mem_reg[sw_req.addr];
    end

    assign sw_rdata = rdata_reg;
endmodule // cmf_byte_mem

// File: cmf_filter.sv
// message object acceptance mask, time stamp readout and data byte window on APB
// Behaviour
// - id mask bits 31..3, 0 forces match
// - mask bit 2 governs remote request compare
// - mask bit 0 governs extension bit compare
// - read-only 16-bit time stamp per object
// - data window shows byte at page pointer
// - page write reselects byte shown
// - auto-increment index after each data access
// - index wraps modulo eight, no stop
// - received frame overwrites tag fields
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "cmf_consts.svh"
module cmf_filter (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // protocol engine: frame to filter
    input  wire logic                 rx_valid,
    input  wire cmf_pkg::cmf_frame_t  rx_frame,
    output logic [5:0]                rx_accept,
    // protocol engine: store received frame into an object
    input  wire logic                 rx_store,
    input  wire logic [2:0]           rx_store_obj,
    input  wire logic [15:0]          rx_stamp,
    // protocol engine: received data bytes
    input  wire logic                 rx_byte_we,
    input  wire logic [5:0]           rx_byte_addr,
    input  wire logic [7:0]           rx_byte
);
    localparam int N = `CMF_NUM_OBJ;

    cmf_pkg::cmf_bus_state_t state_reg, state_next;
    logic [31:0] mask_reg  [0:N-1];
    logic [31:0] mask_next [0:N-1];
    logic [31:0] tag_reg   [0:N-1];
    logic [31:0] tag_next  [0:N-1];
    logic [15:0] stamp_reg [0:N-1];
    logic [15:0] stamp_next[0:N-1];
    logic [7:0]  page_reg, page_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        err_reg, err_next;
    logic        data_rd_reg, data_rd_next;
    logic [5:0]  accept_reg, accept_next;

    logic [9:0]  word_idx;
    logic [7:0]  reg_idx;
    logic        hit_tag, hit_mask, hit_stamp, hit_data, hit_page, hit_status, mapped;
    logic [2:0]  obj_sel;
    logic [2:0]  byte_idx;
    logic        obj_ok;
    logic [7:0]  mem_rdata;
    cmf_pkg::cmf_mem_req_t mem_req;

    assign word_idx   = paddr[11:2];
    assign reg_idx    = word_idx[7:0];
    assign hit_tag    = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_TAG;
    assign hit_mask   = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_MASK;
    assign hit_stamp  = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_STAMP;
    assign hit_data   = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_DATA;
    assign hit_page   = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_PAGE;
    assign hit_status = word_idx[9:8] == 2'b00 && reg_idx == `CMF_IDX_STATUS;
    assign mapped     = hit_tag | hit_mask | hit_stamp | hit_data | hit_page | hit_status;
    assign obj_sel    = page_reg[`CMF_PAGE_OBJ_LSB +: 3];
    assign byte_idx   = page_reg[`CMF_PAGE_IDX_LSB +: 3];
    // objects beyond the last one read as zero and ignore writes
    assign obj_ok     = obj_sel < 3'(N);

    // the byte store address follows the page register, so a page write is seen at once
    always_comb begin
        mem_req.addr  = {obj_sel, byte_idx};
        mem_req.wdata = pwdata[7:0];
        mem_req.write = state_reg == cmf_pkg::CMF_ACCESS && pwrite && hit_data && obj_ok;
    end

    cmf_byte_mem u_mem (
        .clk       (clk),
        .sw_req    (mem_req),
        .sw_rdata  (mem_rdata),
        .eng_we    (rx_byte_we),
        .eng_addr  (rx_byte_addr),
        .eng_wdata (rx_byte)
    );

    // acceptance: a mask bit of one demands equality, zero forces a match
    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic [31:0] diff;
            diff = 32'h0000_0000;
            diff[31:`CMF_MSK_ID_LSB] = rx_frame.ident ^ tag_reg[i][31:`CMF_MSK_ID_LSB];
            diff[`CMF_MSK_RTR_BIT]   = rx_frame.rtr ^ tag_reg[i][`CMF_MSK_RTR_BIT];
            // the tag register keeps no extension bit here, so compare against rb0 slot
            diff[`CMF_MSK_IDE_BIT]   = rx_frame.ide ^ tag_reg[i][`CMF_TAG_RB0_BIT];
            accept_next[i] = rx_valid && ((diff & mask_reg[i]) == 32'h0000_0000);
        end
    end

    // bus sequencer: one wait state lets the byte store deliver its registered read
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cmf_pkg::CMF_IDLE:   if (psel && !penable) state_next = cmf_pkg::CMF_ACCESS;
            cmf_pkg::CMF_ACCESS: state_next = cmf_pkg::CMF_DONE;
            cmf_pkg::CMF_DONE:   state_next = cmf_pkg::CMF_IDLE;
            default:             state_next = cmf_pkg::CMF_IDLE;
        endcase
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            mask_next[i]  = mask_reg[i];
            tag_next[i]   = tag_reg[i];
            stamp_next[i] = stamp_reg[i];
            if (rx_store && rx_store_obj == 3'(i)) begin
                tag_next[i]   = {rx_frame.ident, rx_frame.rtr, rx_frame.rb1, rx_frame.rb0};
                stamp_next[i] = rx_stamp;
            end
        end
        if (state_reg == cmf_pkg::CMF_ACCESS && pwrite) begin
            if (hit_mask && obj_ok)
                mask_next[obj_sel] = pwdata;
            // software write made after a same-cycle receive keeps the newer value
            if (hit_tag && obj_ok)
                tag_next[obj_sel] = pwdata;
        end
    end

    // page pointer: software picks object and index, data accesses may step the index
    always_comb begin
        page_next = page_reg;
        if (state_reg == cmf_pkg::CMF_ACCESS) begin
            if (pwrite && hit_page)
                page_next = pwdata[7:0];
            if (hit_data && page_reg[`CMF_PAGE_AINC_BIT])
                page_next[`CMF_PAGE_IDX_LSB +: 3] = byte_idx + 3'h1;
        end
    end

    // read-back path: registers are latched at the end of the access cycle; the byte store
    // takes its registered read at that same edge, so its byte is steered out while pready stands
    always_comb begin
        rdata_next   = rdata_reg;
        err_next     = 1'b0;
        data_rd_next = 1'b0;
        if (state_reg == cmf_pkg::CMF_ACCESS) begin
            err_next     = !mapped;
            data_rd_next = hit_data && obj_ok && !pwrite;
            rdata_next   = 32'h0000_0000;
            if (hit_mask && obj_ok)  rdata_next = mask_reg[obj_sel];
            if (hit_tag && obj_ok)   rdata_next = tag_reg[obj_sel];
            if (hit_stamp && obj_ok) rdata_next = {16'h0000, stamp_reg[obj_sel]};
            if (hit_page)            rdata_next = {24'h000000, page_reg};
            if (hit_status)          rdata_next = {26'h0000000, accept_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= cmf_pkg::CMF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg   <= 32'h0000_0000;
            err_reg     <= 1'b0;
            data_rd_reg <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            err_reg     <= err_next;
            data_rd_reg <= data_rd_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            accept_reg <= 6'h00;
        end else begin
            accept_reg <= accept_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            page_reg <= `CMF_PAGE_RESET;
        end else begin
            page_reg <= page_next;
        end
    end

    // data bytes are not reset; the object registers here start from known values
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < N; i++) begin
                mask_reg[i]  <= `CMF_MASK_RESET;
                tag_reg[i]   <= `CMF_TAG_RESET;
                stamp_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                mask_reg[i]  <= mask_next[i];
                tag_reg[i]   <= tag_next[i];
                stamp_reg[i] <= stamp_next[i];
            end
        end
    end

    assign pready    = state_reg == cmf_pkg::CMF_DONE;
    assign prdata    = data_rd_reg ? {24'h000000, mem_rdata} : rdata_reg;
    assign pslverr   = err_reg & pready;
    assign rx_accept = accept_reg;
endmodule // cmf_filter

// File: cmf_filter_sva.sv
// assertions on the ports of the message object filter block
`timescale 1ns/1ns
module cmf_filter_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // apb and accept flags
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  rx_accept
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire hit = paddr inside {12'h3C0, 12'h3D0, 12'h3E0, 12'h3E8, 12'h3EC, 12'h3F0};
    wire rd  = psel && penable && pready && !pwrite;
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_done; pready ##1 !pready; endsequence
    a_ready_time: assert property (s_wait |=> s_done)
        else $error("ready late or held");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_unmapped: assert property (pready && !hit |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (pready && hit |-> !pslverr)
        else $error("error on mapped address");
    a_unmapped_zero: assert property (rd && !hit |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_stamp_width: assert property (rd && paddr == 12'h3E0 |-> prdata[31:16] == 16'h0)
        else $error("stamp wider than 16 bits");
    a_data_width: assert property (rd && paddr == 12'h3E8 |-> prdata[31:8] == 24'h0)
        else $error("data window wider than a byte");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && rx_accept == 6'h00)
        else $error("outputs active after reset");
endmodule // cmf_filter_sva

// File: tb_top.sv
// self-checking bench for the message object filter block
`timescale 1ns/1ns
`include "cmf_consts.svh"
module tb_top;
    logic                clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, vq = 0;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0, prdata, f, tag[6], msk[6], rq[$];
    logic                pready, pslverr, rx_valid = 0, rx_store = 0, rx_byte_we = 0;
    cmf_pkg::cmf_frame_t rx_frame = '0, fr;
    logic [5:0]          rx_accept, rx_byte_addr = 6'h00, aq[$];
    logic [2:0]          rx_store_obj = 3'h0;
    logic [15:0]         rx_stamp = 16'h0000;
    logic [7:0]          rx_byte = 8'h00;
    int                  fail_count = 0, compares = 0, cyc = 0;
    localparam logic [11:0] ad_tag = {2'b00, `CMF_IDX_TAG, 2'b00};
    localparam logic [11:0] ad_mask = {2'b00, `CMF_IDX_MASK, 2'b00};
    localparam logic [11:0] ad_stamp = {2'b00, `CMF_IDX_STAMP, 2'b00};
    localparam logic [11:0] ad_data = {2'b00, `CMF_IDX_DATA, 2'b00};
    localparam logic [11:0] ad_page = {2'b00, `CMF_IDX_PAGE, 2'b00};
    cmf_filter dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_accept(rx_accept), .rx_store(rx_store),
        .rx_store_obj(rx_store_obj), .rx_stamp(rx_stamp), .rx_byte_we(rx_byte_we),
        .rx_byte_addr(rx_byte_addr), .rx_byte(rx_byte));
    always #10 clk = ~clk;
    task automatic final_report;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_acc(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: accept %b expected %b", $time, got, exp);
        end
    endtask
    // the request stays put until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [5:0] acc(input cmf_pkg::cmf_frame_t x);
        logic [31:0] v;
        v = {x.ident, x.rtr, 1'b0, x.ide};
        for (int i = 0; i < 6; i++) acc[i] = ((msk[i] & (v ^ tag[i]) & 32'hFFFF_FFFD) == 0);
    endfunction
    always @(posedge clk) begin
        vq <= rx_valid;
        if (psel && penable && pready && !pwrite && rq.size() > 0)
            chk_rd(prdata, rq.pop_front());
        if (vq && aq.size() > 0)
            chk_acc(rx_accept, aq.pop_front());
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(64604));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdx(ad_mask, 32'h0);
        rdx(12'h004, 32'h0);
        rdx({2'b00, `CMF_IDX_STATUS, 2'b00}, 32'h0);
        for (int o = 0; o < 6; o++) begin
            tag[o] = $urandom;
            msk[o] = (o == 5) ? 32'h0 : (o == 4) ? 32'h5 : $urandom & 32'hFFFF_FFFD;
            apb(1'b1, ad_page, 32'({o[2:0], 4'h0}));
            apb(1'b1, ad_tag, tag[o]);
            apb(1'b1, ad_mask, msk[o]);
            rdx(ad_mask, msk[o]);
            rdx(ad_tag, tag[o]);
        end
        // odd passes reuse a tag and flip extension and remote bits in turn
        for (int k = 0; k < 24; k++) begin
            f = k[0] ? tag[k % 6] : $urandom;
            fr = {f[31:3], f[2] ^ k[2], f[0] ^ k[1], f[1], f[0]};
            aq.push_back(acc(fr));
            rx_frame <= fr;
            rx_valid <= 1'b1;
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        fr = {1'b0, $urandom};
        rx_frame <= fr;
        rx_stamp <= 16'hFFFF;
        rx_store_obj <= 3'h3;
        rx_store <= 1'b1;
        @(posedge clk) rx_store <= 1'b0;
        apb(1'b1, ad_page, 32'h30);
        apb(1'b1, ad_stamp, 32'h0);
        rdx(ad_stamp, 32'h0000_FFFF);
        rdx(ad_tag, {fr.ident, fr.rtr, fr.rb1, fr.rb0});
        for (int i = 0; i < 8; i++) begin
            rx_byte_we <= 1'b1;
            rx_byte_addr <= {3'h2, i[2:0]};
            rx_byte <= {5'h14, i[2:0]};
            @(posedge clk);
        end
        rx_byte_we <= 1'b0;
        apb(1'b1, ad_page, 32'h2E);
        for (int i = 6; i < 16; i++) rdx(ad_data, {24'h0, 5'h14, i[2:0]});
        apb(1'b1, ad_page, 32'h2F);
        apb(1'b1, ad_data, 32'h55);
        apb(1'b1, ad_data, 32'h66);
        apb(1'b1, ad_page, 32'h27);
        rdx(ad_data, 32'h55);
        rdx(ad_data, 32'h55);
        apb(1'b1, ad_page, 32'h20);
        rdx(ad_data, 32'h66);
        repeat (4) @(posedge clk);
        if (rq.size() != 0 || aq.size() != 0) fail_count++;
        final_report();
    end
endmodule // tb_top
bind cmf_filter cmf_filter_sva u_sva (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_accept(rx_accept));
